/* File: pwr_seq_pkg.sv */
// shared constants and types of the power, reset and sleep sequencer
package pwr_seq_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int PRESS_MIN_MS = 16;
  localparam int PRESS_MIN_US = PRESS_MIN_MS * 1000;
  localparam int RESET_PULSE_US = 1000;
  localparam int PREP_US = 10;

  // input vector positions
  localparam int IN_PWR_BTN = 0;
  localparam int IN_RST_BTN = 1;
  localparam int IN_SLP_BTN = 2;
  localparam int IN_LID = 3;
  localparam int IN_PCIE_WAKE = 4;
  localparam int IN_AUX_WAKE = 5;
  localparam int IN_BAT_LOW = 6;
  localparam int IN_OVERTEMP = 7;
  localparam int IN_ALERT = 8;
  localparam int IN_SUPPLY_BAD = 9;
  localparam int IN_RAIL_LOW = 10;
  localparam int N_IN = 11;
  localparam int N_BTN = 4;
  localparam int EV_WDOG = 11;
  localparam int N_EV = 12;

  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_WDOG_LOAD = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;

  // field positions
  localparam int CTL_WDOG_EN = 0;
  localparam int CTL_ALERT_WAKE = 1;
  localparam int CMD_SLEEP_RAM = 0;
  localparam int CMD_SOFT_OFF = 1;
  localparam int CMD_RESET_BUTTON_N = 2;
  localparam int CMD_WDOG_KICK = 3;
  localparam int STATE_LVL_POS = 2;

  // reset values
  localparam logic [N_EV-1:0] ENABLE_RST = 12'h000;
  localparam logic [1:0] CONTROL_RST = 2'h0;
  localparam logic [31:0] WDOG_LOAD_RST = 32'h000f4240;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_PREP = 2'b10,
    ST_RAM = 2'b11
  } pwr_state_type;

endpackage

/* File: pwr_seq.sv */
// power, reset and sleep-state sequencer facing the carrier board
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// R01: power button press wakes from soft-off
// R02: reset button edge triggered, no hold
// R03: carrier holds reset button 16 ms
// R04: carrier reset on button, supply, rail, watchdog, software
// R05: supply_good high means power good
// R06: suspend_imminent_n asserted before suspending
// R07: sleep_ram_n low while in suspend-to-RAM
// R08: soft_off_n low while soft-off
// R09: suspend-to-disk indication not supported
// R10: both wake inputs wake from suspend
// R11: battery low condition is registered
// R12: overtemp input reported as over-temperature
// R13: alert raises management interrupt or wakes
// R14: lid switch presses reported as events
// R15: sleep button presses reported, wake suspend
// R16: watchdog_expired high after watchdog time-out
// R17: buttons qualified by press-width counter
// R18: every carrier input double synchronised
module pwr_seq import pwr_seq_pkg::*; #(
  parameter int unsigned PRESS_TICKS = PRESS_MIN_US,
  parameter int unsigned RESET_TICKS = RESET_PULSE_US,
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic sleep_button_n,
  input wire logic lid_switch_n,
  input wire logic pcie_wake_n,
  input wire logic aux_wake_n,
  input wire logic battery_low_n,
  input wire logic overtemp_in_n,
  input wire logic sideband_alert_n,
  input wire logic supply_good,
  input wire logic main_rail_ok,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic carrier_reset_n,
  output logic suspend_imminent_n,
  output logic sleep_ram_n,
  output logic sleep_disk_n,
  output logic soft_off_n,
  output logic watchdog_expired,
  output logic mgmt_irq_n,
  output logic irq
);

  logic [N_IN-1:0] raw_in;
  logic [N_IN-1:0] sync1;
  logic [N_IN-1:0] sync2;
  logic [N_IN-1:0] active;
  logic [N_IN-1:0] active_q;
  logic [N_BTN-1:0] btn_evt;
  logic [N_EV-1:0] evt;
  logic [N_EV-1:0] status;
  logic [N_EV-1:0] irq_en;
  logic [N_EV-1:0] clr_mask;
  logic [1:0] control;
  logic [31:0] div_cnt;
  logic tick;
  logic [31:0] rst_cnt;
  logic [15:0] prep_cnt;
  logic [31:0] wd_load;
  logic [31:0] wd_cnt;
  logic wd_fire;
  logic kick;
  logic cmd_ram;
  logic cmd_off;
  logic cmd_rst;
  logic wake_off;
  logic wake_ram;
  logic prep_to_ram;
  logic reg_wr_cmd;
  logic rst_held;
  pwr_state_type state;

  // every input enters the synchroniser active low, so an idle board reads all ones
  assign raw_in = {main_rail_ok, supply_good, sideband_alert_n, overtemp_in_n,
                   battery_low_n, aux_wake_n, pcie_wake_n, lid_switch_n,
                   sleep_button_n, reset_button_n, power_button_n};

  // R18: two-stage synchroniser
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end

  // R05: supply_good low counts as asserted fault
  assign active = ~sync2;

  // previous level for edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      active_q <= '0;
    end else begin
      active_q <= active;
    end
  end

  // microsecond enable pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else if (div_cnt == 32'(TICK_DIV - 1)) begin
      div_cnt <= '0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // R17: press-width qualification, one pulse per press
  for (genvar b = 0; b < N_BTN; b++) begin : g_btn
    logic [31:0] cnt;
    always_ff @(posedge mclk) begin
      if (sys_rst || !active[b]) begin
        cnt <= '0;
      end else if (tick && cnt != 32'(PRESS_TICKS)) begin
        cnt <= cnt + 32'h1;
      end
    end
    assign btn_evt[b] = active[b] && tick && (cnt == 32'(PRESS_TICKS - 1));
    // R17: pulse only when the width is reached
    AST_BTN_WIDTH: assert property (@(posedge mclk) disable iff (sys_rst) // R17
      btn_evt[b] |-> $past(active[b], 1) && cnt == 32'(PRESS_TICKS - 1))
      else $error("button event before minimum width");
  end

  // R11 R12 R14 events: qualified presses, asserting edges of levels, watchdog
  assign evt = {wd_fire, active[N_IN-1:N_BTN] & ~active_q[N_IN-1:N_BTN], btn_evt};

  // register write decode
  assign clr_mask = (reg_wr && reg_addr == OFS_CLEAR) ? reg_wdata[N_EV-1:0] : '0;
  assign reg_wr_cmd = reg_wr && reg_addr == OFS_COMMAND;
  assign cmd_ram = reg_wr_cmd && reg_wdata[CMD_SLEEP_RAM];
  assign cmd_off = reg_wr_cmd && reg_wdata[CMD_SOFT_OFF];
  assign cmd_rst = reg_wr_cmd && reg_wdata[CMD_RESET_BUTTON_N];
  assign kick = reg_wr_cmd && reg_wdata[CMD_WDOG_KICK];

  // sticky status; a new event wins over a clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_mask) | evt;
    end
  end

  AST_BAT_LOW: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    evt[IN_BAT_LOW] |=> status[IN_BAT_LOW])
    else $error("battery low not registered");
  AST_OVERTEMP: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    evt[IN_OVERTEMP] |=> status[IN_OVERTEMP])
    else $error("over-temperature not reported");

  // enable and control registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_en <= ENABLE_RST;
      control <= CONTROL_RST;
      wd_load <= WDOG_LOAD_RST;
    end else if (reg_wr) begin
      if (reg_addr == OFS_ENABLE) begin
        irq_en <= reg_wdata[N_EV-1:0];
      end
      if (reg_addr == OFS_CONTROL) begin
        control <= reg_wdata[1:0];
      end
      if (reg_addr == OFS_WDOG_LOAD) begin
        wd_load <= reg_wdata;
      end
    end
  end

  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      unique case (reg_addr)
        OFS_STATUS: reg_rdata <= 32'(status);
        OFS_ENABLE: reg_rdata <= 32'(irq_en);
        OFS_CONTROL: reg_rdata <= 32'(control);
        OFS_WDOG_LOAD: reg_rdata <= wd_load;
        OFS_STATE: reg_rdata <= {19'h0, active, state};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // level interrupt from enabled status bits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_en);
    end
  end

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 irq == $past(|(status & irq_en)))
    else $error("interrupt does not follow enabled status");

  // R13: alert drives management interrupt unless set up for wake
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mgmt_irq_n <= 1'b1;
    end else begin
      mgmt_irq_n <= ~(active[IN_ALERT] && !control[CTL_ALERT_WAKE]);
    end
  end

  AST_ALERT_SMI: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    (active[IN_ALERT] && !control[CTL_ALERT_WAKE]) |=> !mgmt_irq_n)
    else $error("alert did not raise management interrupt");

  // R01 R10 R13 R15: wake sources per state
  assign wake_off = evt[IN_PWR_BTN] || (control[CTL_ALERT_WAKE] && evt[IN_ALERT]);
  assign wake_ram = wake_off || evt[IN_SLP_BTN] || evt[IN_PCIE_WAKE] || evt[IN_AUX_WAKE];

  // sleep state machine
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_OFF;
      prep_to_ram <= 1'b0;
    end else begin
      unique case (state)
        ST_OFF: begin
          if (wake_off) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cmd_ram || cmd_off) begin
            state <= ST_PREP;
            prep_to_ram <= cmd_ram;
          end
        end
        ST_PREP: begin
          if (prep_cnt == 16'h0) begin
            state <= prep_to_ram ? ST_RAM : ST_OFF;
          end
        end
        ST_RAM: begin
          if (wake_ram) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // R06: hold the notice for a fixed time before suspending
  always_ff @(posedge mclk) begin
    if (sys_rst || state != ST_PREP) begin
      prep_cnt <= 16'(PREP_US);
    end else if (tick && prep_cnt != 16'h0) begin
      prep_cnt <= prep_cnt - 16'h1;
    end
  end

  // state indicator pins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      suspend_imminent_n <= 1'b1;
      sleep_ram_n <= 1'b1;
      sleep_disk_n <= 1'b1;
      soft_off_n <= 1'b0;
    end else begin
      // R06: notice during preparation
      suspend_imminent_n <= (state != ST_PREP);
      // R07: low in suspend-to-RAM
      sleep_ram_n <= (state != ST_RAM);
      // R09: no suspend-to-disk state
      sleep_disk_n <= 1'b1;
      // R08: low in soft-off
      soft_off_n <= (state != ST_OFF);
    end
  end

  AST_PWR_WAKE: assert property (@(posedge mclk) disable iff (sys_rst) // R01
    (state == ST_OFF && evt[IN_PWR_BTN]) |=> state == ST_RUN)
    else $error("power press did not leave soft-off");
  AST_SUSP_NOTICE: assert property (@(posedge mclk) disable iff (sys_rst) // R06
    (state == ST_RAM && $past(state) != ST_RAM) |-> $past(!suspend_imminent_n))
    else $error("suspend entered without notice");
  AST_S3_PIN: assert property (@(posedge mclk) disable iff (sys_rst) // R07
    ##1 sleep_ram_n == $past(state != ST_RAM))
    else $error("sleep_ram_n does not track suspend-to-RAM");
  AST_S5_PIN: assert property (@(posedge mclk) disable iff (sys_rst) // R08
    ##1 soft_off_n == $past(state != ST_OFF))
    else $error("soft_off_n does not track soft-off");
  AST_NO_S4: assert property (@(posedge mclk) disable iff (sys_rst) // R09
    sleep_disk_n)
    else $error("suspend-to-disk indication asserted");
  AST_RAM_WAKE: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    (state == ST_RAM && (evt[IN_PCIE_WAKE] || evt[IN_AUX_WAKE])) |=> state == ST_RUN)
    else $error("wake input did not leave suspend");

  // watchdog, counts microseconds while running
  always_ff @(posedge mclk) begin
    if (sys_rst || !control[CTL_WDOG_EN] || state != ST_RUN || kick) begin
      wd_cnt <= wd_load;
    end else if (tick && wd_cnt != 32'h0) begin
      wd_cnt <= wd_cnt - 32'h1;
    end
  end
  assign wd_fire = control[CTL_WDOG_EN] && state == ST_RUN && !kick && tick &&
                   wd_cnt == 32'h1;

  // R16: expiry flag held until its status bit is cleared
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      watchdog_expired <= 1'b0;
    end else begin
      watchdog_expired <= (watchdog_expired && !clr_mask[EV_WDOG]) || wd_fire;
    end
  end

  AST_WD_FLAG: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    wd_fire |=> watchdog_expired && status[EV_WDOG])
    else $error("watchdog expiry not flagged");

  // R02 R04: reset pulse started by events only, not by a held button
  always_ff @(posedge mclk) begin
    if (sys_rst || evt[IN_RST_BTN] || wd_fire || cmd_rst) begin
      rst_cnt <= 32'(RESET_TICKS);
    end else if (tick && rst_cnt != 32'h0) begin
      rst_cnt <= rst_cnt - 32'h1;
    end
  end

  // R04: carrier reset also held while supply or main rail is bad
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      carrier_reset_n <= 1'b0;
    end else begin
      carrier_reset_n <= !(rst_cnt != 32'h0 || active[IN_SUPPLY_BAD] ||
                           active[IN_RAIL_LOW] || state == ST_OFF || state == ST_RAM);
    end
  end

  // R02: marks a reset press whose button is still held down
  always_ff @(posedge mclk) begin
    if (sys_rst || !active[IN_RST_BTN]) begin
      rst_held <= 1'b0;
    end else if (evt[IN_RST_BTN]) begin
      rst_held <= 1'b1;
    end
  end

  AST_RST_BTN: assert property (@(posedge mclk) disable iff (sys_rst) // R04
    evt[IN_RST_BTN] |-> ##2 !carrier_reset_n)
    else $error("reset press did not reset carrier");
  AST_RST_ONCE: assert property (@(posedge mclk) disable iff (sys_rst) // R02
    rst_held |-> !evt[IN_RST_BTN])
    else $error("held reset button retriggered");
  AST_SUPPLY_RST: assert property (@(posedge mclk) disable iff (sys_rst) // R05
    active[IN_SUPPLY_BAD] |=> !carrier_reset_n)
    else $error("supply fault did not hold carrier reset");
  AST_RAIL_RST: assert property (@(posedge mclk) disable iff (sys_rst) // R04
    active[IN_RAIL_LOW] |=> !carrier_reset_n)
    else $error("low main rail did not hold carrier reset");

endmodule

/* File: carrier_model.sv */
// carrier board model: buttons, supplies and sensors on the far side
`timescale 1ns/1ps
module carrier_model (
  input wire logic mclk,
  output logic [10:0] pin
);
  logic [10:0] active = 11'h000;

  // line levels
  // idle lines sit at their pull-up level, supply and rail read good
  assign pin = ~active;

  // press width
  // hold one input asserted for a number of cycles, then release it
  task automatic hold(input int idx, input int cycles);
    @(posedge mclk);
    active[idx] <= 1'b1;
    repeat (cycles) @(posedge mclk);
    active[idx] <= 1'b0;
  endtask
endmodule

/* File: tb_top.sv */
// self-checking bench of the power, reset and sleep sequencer
`timescale 1ns/1ps
module tb_top;
  import pwr_seq_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, rdv, mask;
  logic carrier_reset_n, suspend_imminent_n, sleep_ram_n, sleep_disk_n, soft_off_n;
  logic watchdog_expired, mgmt_irq_n, irq;
  logic [10:0] pin;
  logic [31:0] seed = 32'h679a3c44;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int lows;

  // free-running clock, 4 ns period
  always #2 mclk = ~mclk;

  carrier_model carrier_model_inst (.mclk(mclk), .pin(pin));
  pwr_seq #(.PRESS_TICKS(4), .RESET_TICKS(3), .TICK_DIV(2)) pwr_seq_inst (
    .mclk(mclk), .sys_rst(sys_rst), .power_button_n(pin[IN_PWR_BTN]),
    .reset_button_n(pin[IN_RST_BTN]), .sleep_button_n(pin[IN_SLP_BTN]),
    .lid_switch_n(pin[IN_LID]), .pcie_wake_n(pin[IN_PCIE_WAKE]),
    .aux_wake_n(pin[IN_AUX_WAKE]), .battery_low_n(pin[IN_BAT_LOW]),
    .overtemp_in_n(pin[IN_OVERTEMP]), .sideband_alert_n(pin[IN_ALERT]),
    .supply_good(pin[IN_SUPPLY_BAD]), .main_rail_ok(pin[IN_RAIL_LOW]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .carrier_reset_n(carrier_reset_n),
    .suspend_imminent_n(suspend_imminent_n), .sleep_ram_n(sleep_ram_n),
    .sleep_disk_n(sleep_disk_n), .soft_off_n(soft_off_n),
    .watchdog_expired(watchdog_expired), .mgmt_irq_n(mgmt_irq_n), .irq(irq));

  // xorshift source of repeatable random values
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one-hot status word of an event
  function automatic logic [31:0] ev_bit(input int idx);
    return 32'h1 << idx;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data is taken in the single cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("rst carrier_reset_n", carrier_reset_n, 0);
    chk("rst soft_off_n", soft_off_n, 0);
    rd(OFS_ENABLE);
    chk("enable reset", rdv, 32'(ENABLE_RST));
    rd(OFS_CONTROL);
    chk("control reset", rdv, 32'(CONTROL_RST));
    rd(OFS_WDOG_LOAD);
    chk("wdog load reset", rdv, WDOG_LOAD_RST);
    rd(8'h40);
    chk("unmapped read", rdv, 32'h0);
    carrier_model_inst.hold(IN_PWR_BTN, 3);
    repeat (20) @(posedge mclk);
    rd(OFS_STATE);
    chk("short press ignored", rdv & 32'h3, 32'(ST_OFF));
    carrier_model_inst.hold(IN_PWR_BTN, 20 + int'(xs() % 8));
    repeat (10) @(posedge mclk);
    rd(OFS_STATE);
    chk("power on state", rdv & 32'h3, 32'(ST_RUN));
    chk("power on soft_off_n", soft_off_n, 1);
    chk("power on carrier_reset_n", carrier_reset_n, 1);
    wr(OFS_CLEAR, 32'hfff);
    for (int i = IN_SLP_BTN; i <= IN_ALERT; i++) begin
      mask = xs() & 32'hfff;
      wr(OFS_ENABLE, mask);
      fork
        carrier_model_inst.hold(i, 40);
      join_none
      repeat (24) @(posedge mclk);
      chk("mgmt_irq_n", mgmt_irq_n, (i == IN_ALERT) ? 0 : 1);
      chk("irq", irq, 32'(mask[i]));
      rd(OFS_STATUS);
      chk("status event", rdv, ev_bit(i));
      rd(OFS_STATE);
      chk("state level", rdv & ev_bit(i + STATE_LVL_POS), ev_bit(i + STATE_LVL_POS));
      repeat (24) @(posedge mclk);
      wr(OFS_CLEAR, ev_bit(i));
      rd(OFS_STATUS);
      chk("status cleared", rdv, 32'h0);
      chk("irq cleared", irq, 0);
    end
    wr(OFS_COMMAND, ev_bit(CMD_SLEEP_RAM));
    repeat (4) @(posedge mclk);
    chk("suspend notice", suspend_imminent_n, 0);
    repeat (30) @(posedge mclk);
    rd(OFS_STATE);
    chk("ram state", rdv & 32'h3, 32'(ST_RAM));
    chk("sleep_ram_n low", sleep_ram_n, 0);
    carrier_model_inst.hold(IN_AUX_WAKE, 6);
    repeat (8) @(posedge mclk);
    rd(OFS_STATE);
    chk("wake state", rdv & 32'h3, 32'(ST_RUN));
    chk("sleep_ram_n high", sleep_ram_n, 1);
    repeat (20) @(posedge mclk);
    chk("reset released", carrier_reset_n, 1);
    lows = 0;
    fork
      carrier_model_inst.hold(IN_RST_BTN, 80);
      repeat (82) @(posedge mclk) lows += int'(!carrier_reset_n);
    join
    chk("reset pulse width", 32'(lows >= 4 && lows <= 8), 1);
    chk("held button no hold", carrier_reset_n, 1);
    for (int i = IN_SUPPLY_BAD; i <= IN_RAIL_LOW; i++) begin
      fork
        carrier_model_inst.hold(i, 10);
      join_none
      repeat (7) @(posedge mclk);
      chk("supply reset", carrier_reset_n, 0);
      repeat (30) @(posedge mclk);
      chk("supply recovered", carrier_reset_n, 1);
    end
    wr(OFS_WDOG_LOAD, 32'h5);
    wr(OFS_CONTROL, ev_bit(CTL_WDOG_EN));
    // kicks every six cycles keep a five-tick watchdog from expiring
    repeat (3) begin
      repeat (4) @(posedge mclk);
      wr(OFS_COMMAND, ev_bit(CMD_WDOG_KICK));
    end
    chk("kicked watchdog quiet", watchdog_expired, 0);
    repeat (30) @(posedge mclk);
    chk("watchdog fired", watchdog_expired, 1);
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CLEAR, ev_bit(EV_WDOG));
    repeat (2) @(posedge mclk);
    chk("watchdog cleared", watchdog_expired, 0);
    repeat (20) @(posedge mclk);
    wr(OFS_COMMAND, ev_bit(CMD_RESET_BUTTON_N));
    repeat (3) @(posedge mclk);
    chk("software reset", carrier_reset_n, 0);
    wr(OFS_COMMAND, ev_bit(CMD_SOFT_OFF));
    repeat (40) @(posedge mclk);
    chk("soft-off entered", soft_off_n, 0);
    chk("disk state unused", sleep_disk_n, 1);
    // alert set up as a wake source leaves soft-off and raises no management interrupt
    wr(OFS_CONTROL, ev_bit(CTL_ALERT_WAKE));
    fork
      carrier_model_inst.hold(IN_ALERT, 10);
    join_none
    repeat (6) @(posedge mclk);
    chk("alert wake no smi", mgmt_irq_n, 1);
    repeat (10) @(posedge mclk);
    rd(OFS_STATE);
    chk("alert wake state", rdv & 32'h3, 32'(ST_RUN));
    // sleep button press wakes from suspend-to-RAM
    wr(OFS_COMMAND, ev_bit(CMD_SLEEP_RAM));
    repeat (30) @(posedge mclk);
    chk("second ram entry", sleep_ram_n, 0);
    carrier_model_inst.hold(IN_SLP_BTN, 16);
    repeat (4) @(posedge mclk);
    rd(OFS_STATE);
    chk("sleep button wake", rdv & 32'h3, 32'(ST_RUN));
    wrap_up();
  end
endmodule
